// [acr_regs.sv]
// Converter configuration register and conversion result register with read protection.
`timescale 1ns/100ps
// Behaviour
// - input buffer pair field bits 9:8, reset 3, decodes negative/positive enables.
// - reference select bits 5:4, reset 0, decodes external, internal or supply.
// - bits 1..3 enable the three low-voltage channels, reset zero.
// - bit 0 enables high-voltage channel 0, reset zero.
// - with all four enables zero, channel 0 counts as enabled.
// - read-only 24-bit result at address 4, reset zero, writes ignored.
// - each result read drives ready bit and ready pin high (inactive).
// - result can be read repeatedly until a new one replaces it.
// - no new result is loaded while a result read is in progress.
// - append-status mode makes result reads 32 bits with status after result, 24 bits in short-word mode.
// - short-word mode rounds result to 16 bits and presents 16 bits.
module acr_regs
	import acr_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Register port from the serial interface.
	input  wire acr_req_t    req,
	input  wire logic        rd_busy,
	output logic [31:0]      rdata,
	output logic [5:0]       rd_len,
	// Interface configuration bits.
	input  wire logic        append_status,
	input  wire logic        short_word_length,
	// Conversion engine side.
	input  wire logic        conv_valid,
	input  wire logic [23:0] conv_data,
	input  wire logic [7:0]  status_in,
	output logic             conv_taken,
	// Status and decoded controls.
	output logic             ready_n,
	output logic             dout_ready_n,
	output acr_ctrl_t        ctrl
);

	// Round a full result to 16 bits, saturating at the top code.
	function automatic logic [15:0] round16(input logic [23:0] v);
		logic [16:0] s;
		s = {1'b0, v[23:8]} + {16'h0000, v[7]};
		round16 = s[16] ? 16'hFFFF : s[15:0];
	endfunction : round16

	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;
	logic [23:0] result_reg;
	logic [23:0] result_next;
	logic [7:0]  status_reg;
	logic [7:0]  status_next;
	logic        ready_n_reg;
	logic        ready_n_next;
	logic        pend_reg;
	logic        pend_next;
	logic [23:0] pend_data_reg;
	logic [7:0]  pend_stat_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [5:0]  rd_len_reg;
	logic [5:0]  rd_len_next;

	// Address decode for the two registers.
	wire         cfg_wr      = req.wr && (req.addr == ADDR_CONV_CFG);
	wire         cfg_rd      = req.rd && (req.addr == ADDR_CONV_CFG);
	wire         res_rd      = req.rd && (req.addr == ADDR_CONV_RESULT);
	wire         read_hold   = res_rd || rd_busy;
	// A fresh conversion beats a parked one, so a result that arrives on the release cycle is not lost.
	wire [23:0]  new_data    = (pend_reg && !conv_valid) ? pend_data_reg : conv_data;
	wire [7:0]   new_stat    = (pend_reg && !conv_valid) ? pend_stat_reg : status_in;
	wire         new_avail   = pend_reg || conv_valid;
	wire         load_result = new_avail && !read_hold;
	wire [23:0]  shaped      = short_word_length ? {8'h00, round16(new_data)} : new_data;
	wire [3:0]   chan_bits   = cfg_reg[3:0];

	// Configuration writes touch only writable bits; bit 7 and bits 15:10 stay zero.
	assign cfg_next = cfg_wr ? (req.wdata & CONV_CFG_WMASK) : cfg_reg;

	// Result loads a shaped word; register writes never reach it.
	assign result_next = load_result ? shaped : result_reg;
	assign status_next = load_result ? new_stat : status_reg;

	// A result that arrives during a read is parked and loaded after the read ends.
	assign pend_next = read_hold ? new_avail : 1'b0;

	// A read clears ready; a new load sets it, and no load happens in a read cycle, since the read parks it.
	assign ready_n_next = load_result ? 1'b0 : (res_rd ? 1'b1 : ready_n_reg);

	// Read data and length of the transfer.
	assign rdata_next = cfg_rd ? {16'h0000, cfg_reg}
		: res_rd ? (append_status ? (short_word_length ? {8'h00, result_reg[15:0], status_reg}
		                                              : {result_reg, status_reg})
		                          : {8'h00, result_reg})
		: 32'h0000_0000;
	assign rd_len_next = res_rd ? (append_status ? (short_word_length ? 6'd24 : 6'(APPEND_W))
		                                         : (short_word_length ? 6'(SHORT_W) : 6'(RESULT_W)))
		: (cfg_rd ? 6'd16 : 6'd0);

	// State registers.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg_reg       <= CONV_CFG_RESET;
			result_reg    <= CONV_RESULT_RESET;
			status_reg    <= STATUS_RESET;
			ready_n_reg   <= 1'b1;
			pend_reg      <= 1'b0;
			pend_data_reg <= CONV_RESULT_RESET;
			pend_stat_reg <= STATUS_RESET;
			rdata_reg     <= 32'h0000_0000;
			rd_len_reg    <= 6'd0;
		end
		else
		begin
			cfg_reg     <= cfg_next;
			result_reg  <= result_next;
			status_reg  <= status_next;
			ready_n_reg <= ready_n_next;
			pend_reg    <= pend_next;
			rdata_reg   <= rdata_next;
			rd_len_reg  <= rd_len_next;
			if (conv_valid)
			begin
				pend_data_reg <= conv_data;
				pend_stat_reg <= status_in;
			end
		end
	end

	// Outputs; the ready pin mirrors the ready bit outside of data shifting.
	assign rdata        = rdata_reg;
	assign rd_len       = rd_len_reg;
	assign ready_n      = ready_n_reg;
	assign dout_ready_n = ready_n_reg;
	assign conv_taken   = conv_valid;

	// Decoded front end controls; the host owns the internal reference enable.
	assign ctrl.ain_buf_neg    = cfg_reg[AIN_BUF_LSB];
	assign ctrl.ain_buf_pos    = cfg_reg[AIN_BUF_LSB + 1];
	assign ctrl.ref_external   = cfg_reg[REF_SEL_LSB +: 2] == REF_EXTERNAL;
	assign ctrl.ref_internal   = cfg_reg[REF_SEL_LSB +: 2] == REF_INTERNAL;
	assign ctrl.ref_supply     = cfg_reg[REF_SEL_LSB +: 2] == REF_SUPPLY;
	assign ctrl.channel_active = (chan_bits == 4'h0) ? 4'h1 : chan_bits;

	// Checks.
	chk_chan_default: assert property (@(posedge mclk) disable iff (!arst_n)
		(cfg_reg[3:0] == 4'h0) |-> ctrl.channel_active == 4'h1) else $error("channel 0 not defaulted");
	chk_chan_direct: assert property (@(posedge mclk) disable iff (!arst_n)
		(cfg_reg[3:0] != 4'h0) |-> ctrl.channel_active == cfg_reg[3:0]) else $error("channel enables wrong");
	chk_buf_decode: assert property (@(posedge mclk) disable iff (!arst_n)
		{ctrl.ain_buf_pos, ctrl.ain_buf_neg} == cfg_reg[9:8]) else $error("buffer decode wrong");
	chk_ref_decode: assert property (@(posedge mclk) disable iff (!arst_n)
		(cfg_reg[5:4] == 2'b10) |-> ctrl.ref_internal && !ctrl.ref_external && !ctrl.ref_supply)
		else $error("reference decode wrong");
	chk_bit7_zero: assert property (@(posedge mclk) disable iff (!arst_n)
		cfg_reg[7] == 1'b0 && cfg_reg[15:10] == 6'h00) else $error("reserved bits set");
	chk_result_write: assert property (@(posedge mclk) disable iff (!arst_n)
		(req.wr && req.addr == ADDR_CONV_RESULT && !new_avail) |=> $stable(result_reg))
		else $error("result changed by write");
	chk_read_ready: assert property (@(posedge mclk) disable iff (!arst_n)
		(res_rd && !load_result) |=> ready_n && dout_ready_n) else $error("ready not cleared on read");
	chk_read_block: assert property (@(posedge mclk) disable iff (!arst_n)
		(rd_busy && !res_rd) |=> $stable(result_reg)) else $error("result updated during read");
	chk_read_repeat: assert property (@(posedge mclk) disable iff (!arst_n)
		(res_rd && !new_avail) ##1 (res_rd && !new_avail) |=> $stable(rdata)) else $error("repeat read differs");
	chk_append_len: assert property (@(posedge mclk) disable iff (!arst_n)
		(res_rd && append_status && !short_word_length) |=> rd_len == 6'd32 && rdata[7:0] == $past(status_reg))
		else $error("append length wrong");
	chk_short_len: assert property (@(posedge mclk) disable iff (!arst_n)
		(res_rd && !append_status && short_word_length) |=> rd_len == 6'd16 && rdata[31:16] == 16'h0000)
		else $error("short length wrong");

	// The remaining reference codes must each select exactly one source, or none for the reserved code.
	// A stray second source would tie two reference nodes together in the front end.
	chk_ref_external: assert property (@(posedge mclk) disable iff (!arst_n)
		(cfg_reg[5:4] == 2'b00) |-> ctrl.ref_external && !ctrl.ref_internal && !ctrl.ref_supply)
		else $error("external reference decode wrong");
	chk_ref_supply: assert property (@(posedge mclk) disable iff (!arst_n)
		(cfg_reg[5:4] == 2'b11) |-> ctrl.ref_supply && !ctrl.ref_external && !ctrl.ref_internal)
		else $error("supply reference decode wrong");
	chk_ref_reserved: assert property (@(posedge mclk) disable iff (!arst_n)
		(cfg_reg[5:4] == 2'b01) |-> !ctrl.ref_supply && !ctrl.ref_external && !ctrl.ref_internal)
		else $error("reserved reference selects a source");

	// At least one channel is always converted, whatever software wrote.
	chk_chan_nonzero: assert property (@(posedge mclk) disable iff (!arst_n)
		ctrl.channel_active != 4'h0)
		else $error("no channel active");

	// A configuration write lands whole in the next cycle, masked to the writable bits.
	chk_cfg_write: assert property (@(posedge mclk) disable iff (!arst_n)
		cfg_wr |=> cfg_reg == ($past(req.wdata) & CONV_CFG_WMASK))
		else $error("configuration write lost");

	// The ready pin and the ready bit never disagree outside of shifting.
	chk_ready_pin: assert property (@(posedge mclk) disable iff (!arst_n)
		dout_ready_n == ready_n)
		else $error("ready pin differs from ready bit");

	// Every load announces itself by pulling ready low in the next cycle.
	chk_load_ready: assert property (@(posedge mclk) disable iff (!arst_n)
		load_result |=> !ready_n)
		else $error("ready not set by load");

	// A full-length load stores the incoming word unchanged.
	chk_load_value: assert property (@(posedge mclk) disable iff (!arst_n)
		(load_result && !short_word_length) |=> result_reg == $past(new_data))
		else $error("loaded result wrong");

	// A short load never leaves anything in the upper byte.
	chk_short_round: assert property (@(posedge mclk) disable iff (!arst_n)
		(load_result && short_word_length) |=> result_reg[23:16] == 8'h00)
		else $error("short result too wide");

	// A result arriving during a read is parked rather than dropped.
	chk_park_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		(new_avail && read_hold) |=> pend_reg)
		else $error("result dropped during read");

	// Once the read ends, the parked word is loaded in the very next cycle unless a fresh conversion arrives then.
	chk_park_release: assert property (@(posedge mclk) disable iff (!arst_n)
		(pend_reg && !read_hold && !conv_valid && !short_word_length) |=> !pend_reg && result_reg == $past(pend_data_reg))
		else $error("parked result not released");

	// Reads of unmapped addresses answer with nothing to shift.
	chk_unmapped_read: assert property (@(posedge mclk) disable iff (!arst_n)
		(req.rd && req.addr != ADDR_CONV_CFG && req.addr != ADDR_CONV_RESULT) |=> rdata == 32'h0000_0000 && rd_len == 6'd0)
		else $error("unmapped read not empty");

	// The configuration register is always shifted as one 16-bit word.
	chk_cfg_len: assert property (@(posedge mclk) disable iff (!arst_n)
		cfg_rd |=> rd_len == 6'd16 && rdata[31:16] == 16'h0000)
		else $error("configuration read length wrong");

	// A plain result read is 24 bits with nothing above them.
	chk_plain_len: assert property (@(posedge mclk) disable iff (!arst_n)
		(res_rd && !append_status && !short_word_length) |=> rd_len == 6'd24 && rdata[31:24] == 8'h00)
		else $error("plain result length wrong");

	// Short words with status make a 24-bit transfer, status last.
	chk_short_append: assert property (@(posedge mclk) disable iff (!arst_n)
		(res_rd && append_status && short_word_length) |=> rd_len == 6'd24 && rdata[31:24] == 8'h00)
		else $error("short append length wrong");

	// Conversions are always accepted; parking handles the read collision.
	chk_taken_echo: assert property (@(posedge mclk) disable iff (!arst_n)
		conv_taken == conv_valid)
		else $error("conversion not accepted");

	// Main scenarios worth seeing at least once.
	cov_parked: cover property (@(posedge mclk) disable iff (!arst_n) conv_valid && rd_busy ##[1:20] load_result);
	cov_release_tie: cover property (@(posedge mclk) disable iff (!arst_n) pend_reg && !read_hold && conv_valid);
	cov_append: cover property (@(posedge mclk) disable iff (!arst_n) res_rd && append_status);
	cov_short: cover property (@(posedge mclk) disable iff (!arst_n) load_result && short_word_length);
	cov_default: cover property (@(posedge mclk) disable iff (!arst_n) cfg_wr && req.wdata[3:0] == 4'h0);

endmodule : acr_regs

// [acr_pkg.sv]
// Package for the converter configuration and conversion result register bank.
package acr_pkg;

	// Register addresses on the internal register port.
	localparam logic [3:0]  ADDR_CONV_CFG      = 4'h3;
	localparam logic [3:0]  ADDR_CONV_RESULT   = 4'h4;

	// Converter configuration field positions.
	localparam int          AIN_BUF_LSB        = 8;
	localparam int          FIXED_ONE_BIT      = 6;
	localparam int          REF_SEL_LSB        = 4;

	// Values after reset and the configuration write mask.
	localparam logic [15:0] CONV_CFG_RESET     = 16'h0340;
	localparam logic [15:0] CONV_CFG_WMASK     = 16'h037F;
	localparam logic [23:0] CONV_RESULT_RESET  = 24'h00_0000;
	localparam logic [7:0]  STATUS_RESET       = 8'h00;

	// Result and status widths.
	localparam int          RESULT_W           = 24;
	localparam int          SHORT_W            = 16;
	localparam int          APPEND_W           = 32;

	// Reference source codes.
	typedef enum logic [1:0] {
		REF_EXTERNAL = 2'b00,
		REF_RESERVED = 2'b01,
		REF_INTERNAL = 2'b10,
		REF_SUPPLY   = 2'b11
	} acr_ref_t;

	// Decoded controls handed to the analog front end.
	typedef struct packed {
		logic       ain_buf_pos;
		logic       ain_buf_neg;
		logic       ref_external;
		logic       ref_internal;
		logic       ref_supply;
		logic [3:0] channel_active;
	} acr_ctrl_t;

	// Register port request.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} acr_req_t;

endpackage : acr_pkg

// [acr_host.sv]
// Host model that drives the register port of the converter register bank.
`timescale 1ns/100ps
module acr_host
	import acr_pkg::*;
(
	// Clock and register port.
	input  wire logic        mclk,
	output acr_req_t         req,
	input  wire logic [31:0] rdata
);
	logic [31:0] rd_val;
	initial req = '0;
	// One strobe cycle, held until the edge that takes it; read data is taken in the answer cycle.
	// Ready is never polled to time the next result, since it stays high after a read.
	// Choosing the internal reference is paired with the mode register enable, outside this bank.
	task automatic access(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1 req = '{w, !w, a, d | ((a == ADDR_CONV_CFG) ? 16'h0040 : 16'h0000)};
		@(posedge mclk);
		#1 req = '0;
		rd_val = rdata;
	endtask : access
endmodule : acr_host

// [adc_config_and_result_regs_bench.sv]
// Self-checking bench for the converter configuration and result register bank.
`timescale 1ns/100ps
module adc_config_and_result_regs_bench import acr_pkg::*;;
	logic        mclk, arst_n, rd_busy, append_status, short_word_length, conv_valid;
	logic        conv_taken, ready_n, dout_ready_n;
	logic [23:0] conv_data;
	logic [7:0]  status_in;
	logic [31:0] rdata;
	logic [5:0]  rd_len;
	acr_req_t    req;
	acr_ctrl_t   ctrl;
	int          num_errors = 0;
	int          comparisons = 0;
	acr_regs dut (.mclk(mclk), .arst_n(arst_n), .req(req), .rd_busy(rd_busy), .rdata(rdata), .rd_len(rd_len),
		.append_status(append_status), .short_word_length(short_word_length), .conv_valid(conv_valid),
		.conv_data(conv_data), .status_in(status_in), .conv_taken(conv_taken), .ready_n(ready_n),
		.dout_ready_n(dout_ready_n), .ctrl(ctrl));
	acr_host host (.mclk(mclk), .req(req), .rdata(rdata));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask : chk
	task automatic finish_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// One conversion pulse; the result lands at the edge that takes it unless a read holds it off.
	task automatic conv(input logic [23:0] d, input logic [7:0] s);
		@(posedge mclk);
		#1 conv_valid = 1'b1;
		conv_data = d;
		status_in = s;
		#1 chk("conv_taken", 1, conv_taken);
		@(posedge mclk);
		#1 conv_valid = 1'b0;
	endtask : conv
	task automatic rd_res(input logic [31:0] e, input logic [5:0] l);
		host.access(1'b0, ADDR_CONV_RESULT, 16'h0000);
		chk("result", e, host.rd_val);
		chk("rd_len", {26'h0, l}, {26'h0, rd_len});
		chk("ready_n", 1, {ready_n, dout_ready_n} == 2'b11);
	endtask : rd_res
	task automatic t_reset;
		chk("ctrl", 9'h1C1, ctrl);
		host.access(1'b0, ADDR_CONV_CFG, 16'h0000);
		chk("cfg", 32'h0000_0340, host.rd_val);
		rd_res(32'h0000_0000, 6'h18);
	endtask : t_reset
	task automatic t_cfg;
		logic [1:0]  c;
		logic [15:0] w;
		for (int i = 0; i < 5; i++)
		begin
			c = 2'(i);
			w = {6'h0, c, 2'b00, c, (i < 4) ? 4'(1 << i) : 4'h0};
			host.access(1'b1, ADDR_CONV_CFG, w);
			chk("ctrl", {c, c == 2'b00, c == 2'b10, c == 2'b11, (i < 4) ? 4'(1 << i) : 4'h1}, ctrl);
			host.access(1'b0, ADDR_CONV_CFG, 16'h0000);
			chk("cfg", {16'h0, w | 16'h0040}, host.rd_val);
		end
	endtask : t_cfg
	task automatic t_result;
		conv(24'hA5_5A3C, 8'h21);
		chk("ready_low", 0, {ready_n, dout_ready_n});
		rd_res(32'h00A5_5A3C, 6'h18);
		host.access(1'b1, ADDR_CONV_RESULT, 16'hFFFF);
		rd_res(32'h00A5_5A3C, 6'h18);
		host.access(1'b0, 4'h7, 16'h0000);
		chk("unmapped", 32'h0000_0000, host.rd_val);
	endtask : t_result
	task automatic t_busy;
		rd_busy = 1'b1;
		conv(24'h12_3456, 8'h00);
		chk("ready_held", 1, ready_n);
		rd_res(32'h00A5_5A3C, 6'h18);
		rd_busy = 1'b0;
		@(posedge mclk);
		#1 chk("ready_late", 0, ready_n);
		rd_res(32'h0012_3456, 6'h18);
	endtask : t_busy
	task automatic t_modes;
		append_status = 1'b1;
		conv(24'h01_0203, 8'h5C);
		rd_res(32'h0102_035C, 6'h20);
		append_status = 1'b0;
		short_word_length = 1'b1;
		conv(24'h12_3480, 8'h00);
		rd_res(32'h0000_1235, 6'h10);
		append_status = 1'b1;
		conv(24'hFF_FF90, 8'h7E);
		rd_res(32'h00FF_FF7E, 6'h18);
		append_status = 1'b0;
		short_word_length = 1'b0;
	endtask : t_modes
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Watchdog so a stuck run still reaches the verdict.
	initial
	begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		finish_test();
	end
	initial
	begin
		{arst_n, rd_busy, append_status, short_word_length, conv_valid, conv_data, status_in} = '0;
		repeat (4) @(posedge mclk);
		#1 arst_n = 1'b1;
		t_reset();
		t_cfg();
		t_result();
		t_busy();
		t_modes();
		finish_test();
	end
endmodule : adc_config_and_result_regs_bench
